// [rtl/icl_interrupt_condition_logic.sv]
/*
 * interrupt condition, mask, compare, transmit state, receive condition
 * and indicate-port enable logic behind the byte-wide management bus.
 * assumes address, write data and parity are stable while mgmt_cs is high;
 * mgmt_cs and the parity enable pin are synchronised; other inputs come from logic on clk.
 */
// Contract
// - interrupt asserted when any condition bit and its mask bit are both one
// - condition register at address 02, always readable, conditionally writable
// - bit 0 set on request-data parity error while parity checking enabled
// - bit 1 set on management write parity error while parity enable pin high
// - bit 2 set on any write to a read-only address
// - conditional writes keep every bit differing from its compare register
// - bit 3 set whenever a conditional write is blocked by mismatch
// - bit 3 stays set until host clears it by a write
// - A indicate pins driven only while A indicate enable is one
// - B indicate pins driven only while B indicate enable is one
// - active mode with invalid source: at most four halt pairs, then idle
// - mask register at 03, read-write, cleared at reset
// - bit 4 set when link error counter reaches zero, also at reset
// - bits 5 and 6 follow unmasked receive conditions, clear only after those
// - bit 7 set while either sense bit is one
`timescale 1ns/100ps
`default_nettype none
module icl_interrupt_condition_logic
    import icl_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = 8'h5A
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic mgmt_cs,
    input wire logic mgmt_rw,
    input wire logic [icl_pkg::ADDR_W-1:0] mgmt_addr,
    input wire logic [7:0] mgmt_data_in,
    input wire logic mgmt_parity_in,
    input wire logic mgmt_parity_enable_pin,
    output logic [7:0] mgmt_data_lines,
    output logic mgmt_parity_out,
    output logic mgmt_data_oe,
    output logic int_n,
    input wire logic req_parity_error,
    input wire logic link_error_event,
    input wire logic [1:0] user_sense,
    input wire logic [7:0] rcv_event_a,
    input wire logic [7:0] rcv_event_b,
    input wire logic a_ind_parity_in,
    input wire logic a_ind_control_in,
    input wire logic [7:0] a_ind_data_in,
    input wire logic b_ind_parity_in,
    input wire logic b_ind_control_in,
    input wire logic [7:0] b_ind_data_in,
    output logic a_ind_parity,
    output logic a_ind_control,
    output logic [7:0] a_ind_data,
    output logic a_ind_oe,
    output logic b_ind_parity,
    output logic b_ind_control,
    output logic [7:0] b_ind_data,
    output logic b_ind_oe,
    input wire logic tx_pair_valid,
    input wire logic [9:0] tx_pair_in,
    output logic [9:0] tx_pair_out
);
    import icl_pkg::*;

    function automatic logic is_read_only(input logic [4:0] a);
        is_read_only = (a == RO_08) || (a == RO_0F) || (a == RO_10) || (a == RO_13) || (a == RO_14) ||
                       (a == RO_16) || (a == ADDR_ID) || (a == RO_19) || (a == RO_1E) || (a == RO_1F);
    endfunction

    // bits differing from the compare value keep their current value
    function automatic logic [7:0] cond_write(input logic [7:0] cur, input logic [7:0] cmp,
                                              input logic [7:0] wdata);
        cond_write = ((cur ^ cmp) & cur) | (~(cur ^ cmp) & wdata);
    endfunction

    logic cs_s1_r, cs_s2_r, cs_s3_r, cs_lvl_r, pe_s1_r, pe_s2_r, pe_s3_r, pe_lvl_r;
    logic cs_s1_nxt, cs_s2_nxt, cs_s3_nxt, cs_lvl_nxt, pe_s1_nxt, pe_s2_nxt, pe_s3_nxt, pe_lvl_nxt;
    logic [7:0] cond_r, mask_r, tsr_r, cfg_r, lem_r, cmp_cond_r, cmp_tsr_r;
    logic [7:0] cond_nxt, mask_nxt, tsr_nxt, cfg_nxt, lem_nxt, cmp_cond_nxt, cmp_tsr_nxt;
    logic [7:0] rcr_r [2];
    logic [7:0] rcm_r [2];
    logic [7:0] rcc_r [2];
    logic [7:0] rcr_nxt [2];
    logic [7:0] rcm_nxt [2];
    logic [7:0] rcc_nxt [2];
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_par_r, rd_par_nxt, rd_oe_r, rd_oe_nxt, int_n_r, int_n_nxt;
    logic [9:0] a_ind_r, a_ind_nxt, b_ind_r, b_ind_nxt;
    logic a_oe_r, a_oe_nxt, b_oe_r, b_oe_nxt;
    logic [2:0] halt_cnt_r, halt_cnt_nxt;
    logic [9:0] tx_out_r, tx_out_nxt;
    logic cs_take, wr, rd, par_err, rej_set, cwi_set, lem_hit, filt_on, rsel;

    always_comb begin
        cs_s1_nxt = mgmt_cs;
        cs_s2_nxt = cs_s1_r;
        cs_s3_nxt = cs_s2_r;
        cs_lvl_nxt = (cs_s2_r == cs_s3_r) ? cs_s3_r : cs_lvl_r;
        pe_s1_nxt = mgmt_parity_enable_pin;
        pe_s2_nxt = pe_s1_r;
        pe_s3_nxt = pe_s2_r;
        pe_lvl_nxt = (pe_s2_r == pe_s3_r) ? pe_s3_r : pe_lvl_r;
        cs_take = (cs_s2_r == cs_s3_r) && cs_s3_r && !cs_lvl_r;
        wr = cs_take && !mgmt_rw;
        rd = cs_take && mgmt_rw;
        // odd parity over data and parity line
        par_err = wr && pe_lvl_r && !(^{mgmt_data_in, mgmt_parity_in});
        rej_set = 1'b0;
        cwi_set = 1'b0;
        lem_hit = 1'b0;
        rsel = 1'b0;
        cond_nxt = cond_r;
        mask_nxt = mask_r;
        tsr_nxt = tsr_r;
        cfg_nxt = cfg_r;
        lem_nxt = lem_r;
        cmp_cond_nxt = cmp_cond_r;
        cmp_tsr_nxt = cmp_tsr_r;
        rcr_nxt = rcr_r;
        rcm_nxt = rcm_r;
        rcc_nxt = rcc_r;
        if (wr) begin
            case (mgmt_addr)
                ADDR_COND: begin
                    cwi_set = |(cond_r ^ cmp_cond_r);
                    cond_nxt = cond_write(cond_r, cmp_cond_r, mgmt_data_in);
                end
                ADDR_MASK: mask_nxt = mgmt_data_in;
                ADDR_TSR: begin
                    cwi_set = |(tsr_r ^ cmp_tsr_r);
                    tsr_nxt = cond_write(tsr_r, cmp_tsr_r, mgmt_data_in);
                end
                ADDR_LEM: lem_nxt = mgmt_data_in;
                ADDR_CFG: cfg_nxt = mgmt_data_in;
                ADDR_RCR_A, ADDR_RCR_B: begin
                    rsel = (mgmt_addr == ADDR_RCR_B);
                    cwi_set = |(rcr_r[rsel] ^ rcc_r[rsel]);
                    rcr_nxt[rsel] = cond_write(rcr_r[rsel], rcc_r[rsel], mgmt_data_in);
                end
                ADDR_RCM_A: rcm_nxt[0] = mgmt_data_in;
                ADDR_RCM_B: rcm_nxt[1] = mgmt_data_in;
                ADDR_CMP_COND: cmp_cond_nxt = mgmt_data_in;
                ADDR_CMP_TSR: cmp_tsr_nxt = mgmt_data_in;
                ADDR_CMP_RCR_A: rcc_nxt[0] = mgmt_data_in;
                ADDR_CMP_RCR_B: rcc_nxt[1] = mgmt_data_in;
                // read-only targets only raise the flag, contents untouched
                default: rej_set = is_read_only(mgmt_addr);
            endcase
        end
        // link error counter counts down to zero
        if (!(wr && mgmt_addr == ADDR_LEM) && link_error_event && lem_r != 8'h00) begin
            lem_nxt = lem_r - 8'h01;
            lem_hit = (lem_r == 8'h01);
        end
        // hardware sets win over a same-cycle clear
        for (int i = 0; i < 2; i++) begin
            rcr_nxt[i] = rcr_nxt[i] | ((i == 0) ? rcv_event_a : rcv_event_b);
        end
        cond_nxt[BIT_REQ_PAR] = cond_nxt[BIT_REQ_PAR] | (req_parity_error & tsr_r[TSR_PAR_EN_BIT]);
        cond_nxt[BIT_MGMT_PAR] = cond_nxt[BIT_MGMT_PAR] | par_err;
        cond_nxt[BIT_WR_REJ] = cond_nxt[BIT_WR_REJ] | rej_set;
        cond_nxt[BIT_CWI] = cond_nxt[BIT_CWI] | cwi_set;
        cond_nxt[BIT_LEM] = cond_nxt[BIT_LEM] | lem_hit;
        cond_nxt[BIT_RCA] = cond_nxt[BIT_RCA] | (|(rcr_r[0] & rcm_r[0]));
        cond_nxt[BIT_RCB] = cond_nxt[BIT_RCB] | (|(rcr_r[1] & rcm_r[1]));
        cond_nxt[BIT_USER] = cond_nxt[BIT_USER] | (|user_sense);
        int_n_nxt = ~|(cond_r & mask_r);
        // read path: data held, driven while the strobe stays high
        rd_data_nxt = rd_data_r;
        if (rd) begin
            case (mgmt_addr)
                ADDR_COND: rd_data_nxt = cond_r;
                ADDR_MASK: rd_data_nxt = mask_r;
                ADDR_TSR: rd_data_nxt = tsr_r;
                ADDR_LEM: rd_data_nxt = lem_r;
                ADDR_CFG: rd_data_nxt = cfg_r;
                ADDR_RCR_A: rd_data_nxt = rcr_r[0];
                ADDR_RCR_B: rd_data_nxt = rcr_r[1];
                ADDR_RCM_A: rd_data_nxt = rcm_r[0];
                ADDR_RCM_B: rd_data_nxt = rcm_r[1];
                ADDR_ID: rd_data_nxt = ID_VALUE;
                ADDR_CMP_COND: rd_data_nxt = cmp_cond_r;
                ADDR_CMP_TSR: rd_data_nxt = cmp_tsr_r;
                ADDR_CMP_RCR_A: rd_data_nxt = rcc_r[0];
                ADDR_CMP_RCR_B: rd_data_nxt = rcc_r[1];
                default: rd_data_nxt = 8'h00;
            endcase
        end
        rd_par_nxt = ~^rd_data_nxt;
        rd_oe_nxt = rd ? 1'b1 : (rd_oe_r && cs_lvl_nxt);
        // indicate ports
        a_ind_nxt = {a_ind_parity_in, a_ind_control_in, a_ind_data_in};
        b_ind_nxt = {b_ind_parity_in, b_ind_control_in, b_ind_data_in};
        a_oe_nxt = cfg_r[CFG_A_IND_EN_BIT];
        b_oe_nxt = cfg_r[CFG_B_IND_EN_BIT];
        // repeat filter on the invalid source
        filt_on = (tsr_r[2:0] == TM_ACTIVE) && (cfg_r[1:0] == SRC_INVALID);
        halt_cnt_nxt = halt_cnt_r;
        tx_out_nxt = tx_out_r;
        if (!filt_on) begin
            halt_cnt_nxt = 3'h0;
            if (tx_pair_valid) begin
                tx_out_nxt = tx_pair_in;
            end
        end else if (tx_pair_valid) begin
            if (tx_pair_in == HALT_PAIR && halt_cnt_r < HALT_LIMIT) begin
                tx_out_nxt = tx_pair_in;
                halt_cnt_nxt = halt_cnt_r + 3'h1;
            end else begin
                tx_out_nxt = IDLE_PAIR;
                halt_cnt_nxt = HALT_LIMIT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_s1_r <= 1'b0;
            cs_s2_r <= 1'b0;
            cs_s3_r <= 1'b0;
            cs_lvl_r <= 1'b0;
            pe_s1_r <= 1'b0;
            pe_s2_r <= 1'b0;
            pe_s3_r <= 1'b0;
            pe_lvl_r <= 1'b0;
            cond_r <= COND_RST;
            mask_r <= MASK_RST;
            tsr_r <= TSR_RST;
            cfg_r <= CFG_RST;
            lem_r <= LEM_RST;
            cmp_cond_r <= 8'h00;
            cmp_tsr_r <= 8'h00;
            rcr_r <= '{8'h00, 8'h00};
            rcm_r <= '{8'h00, 8'h00};
            rcc_r <= '{8'h00, 8'h00};
            rd_data_r <= 8'h00;
            rd_par_r <= 1'b1;
            rd_oe_r <= 1'b0;
            int_n_r <= 1'b1;
            a_ind_r <= 10'h000;
            b_ind_r <= 10'h000;
            a_oe_r <= 1'b0;
            b_oe_r <= 1'b0;
            halt_cnt_r <= 3'h0;
            tx_out_r <= IDLE_PAIR;
        end else begin
            cs_s1_r <= cs_s1_nxt;
            cs_s2_r <= cs_s2_nxt;
            cs_s3_r <= cs_s3_nxt;
            cs_lvl_r <= cs_lvl_nxt;
            pe_s1_r <= pe_s1_nxt;
            pe_s2_r <= pe_s2_nxt;
            pe_s3_r <= pe_s3_nxt;
            pe_lvl_r <= pe_lvl_nxt;
            cond_r <= cond_nxt;
            mask_r <= mask_nxt;
            tsr_r <= tsr_nxt;
            cfg_r <= cfg_nxt;
            lem_r <= lem_nxt;
            cmp_cond_r <= cmp_cond_nxt;
            cmp_tsr_r <= cmp_tsr_nxt;
            rcr_r <= rcr_nxt;
            rcm_r <= rcm_nxt;
            rcc_r <= rcc_nxt;
            rd_data_r <= rd_data_nxt;
            rd_par_r <= rd_par_nxt;
            rd_oe_r <= rd_oe_nxt;
            int_n_r <= int_n_nxt;
            a_ind_r <= a_ind_nxt;
            b_ind_r <= b_ind_nxt;
            a_oe_r <= a_oe_nxt;
            b_oe_r <= b_oe_nxt;
            halt_cnt_r <= halt_cnt_nxt;
            tx_out_r <= tx_out_nxt;
        end
    end

    assign mgmt_data_lines = rd_data_r;
    assign mgmt_parity_out = rd_par_r;
    assign mgmt_data_oe = rd_oe_r;
    assign int_n = int_n_r;
    assign {a_ind_parity, a_ind_control, a_ind_data} = a_ind_r;
    assign {b_ind_parity, b_ind_control, b_ind_data} = b_ind_r;
    assign a_ind_oe = a_oe_r;
    assign b_ind_oe = b_oe_r;
    assign tx_pair_out = tx_out_r;
endmodule // icl_interrupt_condition_logic
`default_nettype wire

// [rtl/icl_pkg.sv]
/*
 * constants for the interrupt condition logic: management addresses,
 * condition bit positions, reset values and transmit filter codes.
 * assumes a 5-bit management address and byte-wide management data.
 */
package icl_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_COND = 5'h02;
    localparam logic [4:0] ADDR_MASK = 5'h03;
    localparam logic [4:0] ADDR_TSR = 5'h04;
    localparam logic [4:0] ADDR_LEM = 5'h05;
    localparam logic [4:0] ADDR_CFG = 5'h07;
    localparam logic [4:0] ADDR_RCR_A = 5'h09;
    localparam logic [4:0] ADDR_RCR_B = 5'h0A;
    localparam logic [4:0] ADDR_RCM_A = 5'h0B;
    localparam logic [4:0] ADDR_RCM_B = 5'h0C;
    localparam logic [4:0] ADDR_ID = 5'h18;
    localparam logic [4:0] ADDR_CMP_COND = 5'h1A;
    localparam logic [4:0] ADDR_CMP_TSR = 5'h1B;
    localparam logic [4:0] ADDR_CMP_RCR_A = 5'h1C;
    localparam logic [4:0] ADDR_CMP_RCR_B = 5'h1D;
    // read-only addresses
    localparam logic [4:0] RO_08 = 5'h08;
    localparam logic [4:0] RO_0F = 5'h0F;
    localparam logic [4:0] RO_10 = 5'h10;
    localparam logic [4:0] RO_13 = 5'h13;
    localparam logic [4:0] RO_14 = 5'h14;
    localparam logic [4:0] RO_16 = 5'h16;
    localparam logic [4:0] RO_19 = 5'h19;
    localparam logic [4:0] RO_1E = 5'h1E;
    localparam logic [4:0] RO_1F = 5'h1F;
    // condition bit positions
    localparam int BIT_REQ_PAR = 0;
    localparam int BIT_MGMT_PAR = 1;
    localparam int BIT_WR_REJ = 2;
    localparam int BIT_CWI = 3;
    localparam int BIT_LEM = 4;
    localparam int BIT_RCA = 5;
    localparam int BIT_RCB = 6;
    localparam int BIT_USER = 7;
    // transmit state and configuration fields
    localparam int TSR_PAR_EN_BIT = 6;
    localparam int CFG_A_IND_EN_BIT = 6;
    localparam int CFG_B_IND_EN_BIT = 7;
    localparam logic [2:0] TM_ACTIVE = 3'h0;
    localparam logic [1:0] SRC_INVALID = 2'h0;
    // reset values
    localparam logic [7:0] COND_RST = 8'h10;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] TSR_RST = 8'hA2;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] LEM_RST = 8'h00;
    // transmit filter
    localparam logic [2:0] HALT_LIMIT = 3'h4;
    localparam logic [9:0] HALT_PAIR = 10'h084;
    localparam logic [9:0] IDLE_PAIR = 10'h3FF;
endpackage

// [verification/icl_host_model.sv]
/* host model for the byte-wide management bus.
   assumes the bench calls access; the design answers on clk. */
`timescale 1ns/100ps
`default_nettype none
module icl_host_model
    import icl_pkg::*;
(
    input wire logic clk,
    output var logic mgmt_cs,
    output var logic mgmt_rw,
    output var logic [icl_pkg::ADDR_W-1:0] mgmt_addr,
    output var logic [7:0] mgmt_data_in,
    output var logic mgmt_parity_in,
    input wire logic [7:0] mgmt_data_lines,
    input wire logic mgmt_data_oe
);
    initial begin
        {mgmt_cs, mgmt_rw, mgmt_addr, mgmt_data_in, mgmt_parity_in} = 16'h4000;
    end
    task automatic access(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic bad,
                          output logic [7:0] q, output logic oe);
        @(posedge clk);
        #1 {mgmt_cs, mgmt_rw, mgmt_addr, mgmt_data_in} = {1'b1, rw, a, d};
        mgmt_parity_in = (~^d) ^ bad;
        repeat (6) @(posedge clk);
        q = mgmt_data_lines;
        oe = mgmt_data_oe;
        // released lines show the inverse so stale values cannot pass
        #1 {mgmt_cs, mgmt_addr, mgmt_data_in} = {1'b0, ~a, ~d};
        repeat (6) @(posedge clk);
    endtask
endmodule // icl_host_model
`default_nettype wire

// [verification/icl_interrupt_condition_logic_tb.sv]
/* self-checking bench for the interrupt condition logic.
   assumes the host model and the bound checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module icl_interrupt_condition_logic_tb;
    import icl_pkg::*;
    localparam logic [7:0] TB_ID = 8'h3C; // arbitrary identity value
    logic clk, srst, mgmt_cs, mgmt_rw, mgmt_parity_in, mgmt_parity_enable_pin, mgmt_parity_out;
    logic mgmt_data_oe, int_n, req_parity_error, link_error_event, tx_pair_valid, oe;
    logic a_ind_parity_in, a_ind_control_in, b_ind_parity_in, b_ind_control_in;
    logic a_ind_parity, a_ind_control, a_ind_oe, b_ind_parity, b_ind_control, b_ind_oe;
    logic [ADDR_W-1:0] mgmt_addr;
    logic [7:0] mgmt_data_in, mgmt_data_lines, rcv_event_a, rcv_event_b, q, cmp_v;
    logic [7:0] a_ind_data_in, b_ind_data_in, a_ind_data, b_ind_data;
    logic [1:0] user_sense;
    logic [9:0] tx_pair_in, tx_pair_out;
    logic [31:0] rnd = 32'h00015C70;
    int err_total = 0;
    int n_checks = 0;
    logic [4:0] ro [10] = '{RO_08, RO_0F, RO_10, RO_13, RO_14, RO_16, ADDR_ID, RO_19, RO_1E, RO_1F};
    icl_interrupt_condition_logic #(.ID_VALUE(TB_ID)) dut (.clk, .srst, .mgmt_cs, .mgmt_rw, .mgmt_addr,
        .mgmt_data_in, .mgmt_parity_in, .mgmt_parity_enable_pin, .mgmt_data_lines, .mgmt_parity_out,
        .mgmt_data_oe, .int_n, .req_parity_error, .link_error_event, .user_sense, .rcv_event_a, .rcv_event_b,
        .a_ind_parity_in, .a_ind_control_in, .a_ind_data_in, .b_ind_parity_in, .b_ind_control_in,
        .b_ind_data_in, .a_ind_parity, .a_ind_control, .a_ind_data, .a_ind_oe, .b_ind_parity, .b_ind_control,
        .b_ind_data, .b_ind_oe, .tx_pair_valid, .tx_pair_in, .tx_pair_out);
    icl_host_model host (.clk, .mgmt_cs, .mgmt_rw, .mgmt_addr, .mgmt_data_in, .mgmt_parity_in,
        .mgmt_data_lines, .mgmt_data_oe);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // differing bits keep their value, matching bits take the write
    function automatic logic [7:0] cw(input logic [7:0] cur, input logic [7:0] cmp, input logic [7:0] wd);
        return (cur & (cur ^ cmp)) | (wd & ~(cur ^ cmp));
    endfunction
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.access(1'b0, a, d, 1'b0, q, oe);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        host.access(1'b1, a, 8'h00, 1'b0, q, oe);
        chk({2'h0, q}, {2'h0, e});
        chk({9'h0, oe}, 10'h001);
    endtask
    task automatic clr();
        host.access(1'b1, ADDR_COND, 8'h00, 1'b0, cmp_v, oe);
        wr(ADDR_CMP_COND, cmp_v);
        wr(ADDR_COND, 8'h00);
    endtask
    task automatic kick(input logic r, input logic l, input logic [7:0] ea, input logic [7:0] eb);
        @(posedge clk);
        #1 {req_parity_error, link_error_event, rcv_event_a, rcv_event_b} = {r, l, ea, eb};
        @(posedge clk);
        #1 {req_parity_error, link_error_event, rcv_event_a, rcv_event_b} = 18'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pair(input logic [9:0] v, input logic [9:0] e);
        @(posedge clk);
        #1 {tx_pair_valid, tx_pair_in} = {1'b1, v};
        @(posedge clk);
        #1 tx_pair_valid = 1'b0;
        chk(tx_pair_out, e);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        #1;
        rnd = lfsr(rnd);
        {a_ind_parity_in, a_ind_control_in, a_ind_data_in} = rnd[9:0];
        {b_ind_parity_in, b_ind_control_in, b_ind_data_in} = rnd[19:10];
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        $display("unexpected at %0t: run limit reached", $time);
        report_and_stop();
    end
    initial begin
        {srst, mgmt_parity_enable_pin, req_parity_error, link_error_event, tx_pair_valid} = 5'h10;
        {rcv_event_a, rcv_event_b, user_sense, tx_pair_in} = 28'h0;
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;
        rdc(ADDR_COND, COND_RST);
        rdc(ADDR_MASK, MASK_RST);
        chk({9'h0, int_n}, 10'h001);
        $display("reset test done");
        foreach (ro[i]) begin
            clr();
            wr(ro[i], rnd[7:0]);
            rdc(ADDR_COND, 8'h04);
        end
        rdc(ADDR_ID, TB_ID);
        wr(ADDR_MASK, 8'h04);
        chk({9'h0, int_n}, 10'h000);
        wr(ADDR_MASK, 8'h00);
        chk({9'h0, int_n}, 10'h001);
        $display("reject and interrupt test done");
        clr();
        kick(1'b1, 1'b0, 8'h00, 8'h00);
        rdc(ADDR_COND, 8'h00);
        wr(ADDR_TSR, 8'h40);
        rdc(ADDR_TSR, cw(TSR_RST, 8'h00, 8'h40));
        rdc(ADDR_COND, 8'h08);
        kick(1'b1, 1'b0, 8'h00, 8'h00);
        wr(ADDR_CMP_COND, 8'h00);
        wr(ADDR_COND, 8'h00);
        rdc(ADDR_COND, cw(8'h09, 8'h00, 8'h00) | 8'h08);
        repeat (50) @(posedge clk);
        rdc(ADDR_COND, 8'h09);
        $display("conditional write test done");
        clr();
        #1 mgmt_parity_enable_pin = 1'b1;
        host.access(1'b0, ADDR_MASK, 8'h00, 1'b1, q, oe);
        rdc(ADDR_COND, 8'h02);
        clr();
        #1 mgmt_parity_enable_pin = 1'b0;
        host.access(1'b0, ADDR_MASK, 8'h00, 1'b1, q, oe);
        rdc(ADDR_COND, 8'h00);
        wr(ADDR_LEM, 8'h01);
        kick(1'b0, 1'b1, 8'h00, 8'h00);
        rdc(ADDR_COND, 8'h10);
        clr();
        wr(ADDR_RCM_A, 8'hFF);
        wr(ADDR_RCM_B, 8'hFF);
        kick(1'b0, 1'b0, {rnd[7:1], 1'b1}, {rnd[15:9], 1'b1});
        clr();
        rdc(ADDR_COND, 8'h60);
        wr(ADDR_RCM_A, 8'h00);
        wr(ADDR_RCM_B, 8'h00);
        clr();
        rdc(ADDR_COND, 8'h00);
        host.access(1'b1, ADDR_RCR_B, 8'h00, 1'b0, cmp_v, oe);
        wr(ADDR_CMP_RCR_B, cmp_v ^ 8'h01);
        wr(ADDR_RCR_B, 8'h00);
        rdc(ADDR_RCR_B, cw(cmp_v, cmp_v ^ 8'h01, 8'h00));
        rdc(ADDR_COND, 8'h08);
        #1 user_sense = rnd[1:0] | 2'h1;
        clr();
        rdc(ADDR_COND, 8'h80);
        #1 user_sense = 2'h0;
        clr();
        rdc(ADDR_COND, 8'h00);
        $display("condition source test done");
        wr(ADDR_CFG, 8'hC0);
        chk({8'h0, a_ind_oe, b_ind_oe}, 10'h003);
        repeat (20) @(posedge clk);
        wr(ADDR_CFG, 8'h00);
        chk({8'h0, a_ind_oe, b_ind_oe}, 10'h000);
        wr(ADDR_CMP_TSR, 8'hE2);
        wr(ADDR_TSR, 8'h00);
        rdc(ADDR_TSR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            pair(HALT_PAIR, i < 4 ? HALT_PAIR : IDLE_PAIR);
        end
        pair(rnd[9:0] | 10'h200, IDLE_PAIR);
        wr(ADDR_CFG, 8'h01);
        pair(HALT_PAIR, HALT_PAIR);
        pair(rnd[9:0], rnd[9:0]);
        $display("indicate and filter test done");
        report_and_stop();
    end
endmodule // icl_interrupt_condition_logic_tb
`default_nettype wire

// [verification/icl_props.sv]
/* checker for the interrupt condition logic ports.
   assumes the bind below onto the design top, one clock, srst high resets. */
`timescale 1ns/100ps
`default_nettype none
module icl_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic mgmt_cs,
    input wire logic mgmt_rw,
    input wire logic [7:0] mgmt_data_lines,
    input wire logic mgmt_parity_out,
    input wire logic mgmt_data_oe,
    input wire logic int_n,
    input wire logic a_ind_parity_in,
    input wire logic a_ind_control_in,
    input wire logic [7:0] a_ind_data_in,
    input wire logic a_ind_parity,
    input wire logic a_ind_control,
    input wire logic [7:0] a_ind_data,
    input wire logic a_ind_oe,
    input wire logic b_ind_parity_in,
    input wire logic b_ind_control_in,
    input wire logic [7:0] b_ind_data_in,
    input wire logic b_ind_parity,
    input wire logic b_ind_control,
    input wire logic [7:0] b_ind_data,
    input wire logic b_ind_oe,
    input wire logic tx_pair_valid,
    input wire logic [9:0] tx_pair_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_rst_all_quiet: assert property ($past(srst) |-> int_n && !mgmt_data_oe && !a_ind_oe && !b_ind_oe)
        else $error("outputs active right after reset");
    a_tx_rst_idle: assert property ($past(srst) |-> tx_pair_out == 10'h3FF)
        else $error("pair out not idle after reset");
    a_tx_hold_out: assert property (!$past(tx_pair_valid) |-> $stable(tx_pair_out))
        else $error("pair out moved without a pair");
    a_rd_oe_cause: assert property ($rose(mgmt_data_oe) |-> $past(mgmt_rw) && $past(mgmt_cs, 3))
        else $error("data drive without a read");
    a_rd_parity_odd: assert property (mgmt_data_oe |-> ^{mgmt_data_lines, mgmt_parity_out})
        else $error("read parity not odd");
    a_rd_oe_drop: assert property ($fell(mgmt_cs) |-> ##[1:6] !mgmt_data_oe)
        else $error("data drive held after strobe");
    a_a_oe_cause: assert property ($changed(a_ind_oe) |-> !$past(mgmt_rw, 2) && $past(mgmt_cs, 3))
        else $error("a enable moved without a write");
    a_b_oe_cause: assert property ($changed(b_ind_oe) |-> !$past(mgmt_rw, 2) && $past(mgmt_cs, 3))
        else $error("b enable moved without a write");
    a_a_data_follow: assert property (a_ind_oe && $past(a_ind_oe) |->
        {a_ind_parity, a_ind_control, a_ind_data} == $past({a_ind_parity_in, a_ind_control_in, a_ind_data_in}))
        else $error("a indicate data wrong");
    a_b_data_follow: assert property (b_ind_oe && $past(b_ind_oe) |->
        {b_ind_parity, b_ind_control, b_ind_data} == $past({b_ind_parity_in, b_ind_control_in, b_ind_data_in}))
        else $error("b indicate data wrong");
endmodule // icl_props
bind icl_interrupt_condition_logic icl_props u_props (.clk, .srst, .mgmt_cs, .mgmt_rw, .mgmt_data_lines,
    .mgmt_parity_out, .mgmt_data_oe, .int_n, .a_ind_parity_in, .a_ind_control_in, .a_ind_data_in,
    .a_ind_parity, .a_ind_control, .a_ind_data, .a_ind_oe, .b_ind_parity_in, .b_ind_control_in,
    .b_ind_data_in, .b_ind_parity, .b_ind_control, .b_ind_data, .b_ind_oe, .tx_pair_valid, .tx_pair_out);
`default_nettype wire
